/* pkg/potr_pkg.sv */
// Package of constants, types and helpers for the frame time-stamp rewrite block.
package potr_pkg;

  localparam int unsigned ID_W       = 80;
  localparam int unsigned TS_W       = 64;
  localparam int unsigned NS_W       = 32;
  localparam int unsigned OFF_W      = 16;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned CNT_W      = 3;
  localparam int unsigned PIPE_DEPTH = 4;

  localparam logic [3:0]  LEN_NONE   = 4'h0;
  localparam logic [3:0]  LEN_RSVD   = 4'h4;
  localparam logic [3:0]  LEN_STAMP  = 4'h8;
  localparam logic [31:0] CRC_INIT   = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY   = 32'hEDB88320;
  localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00;
  localparam logic [15:0] IDX_FIRST  = 16'h0001;
  localparam logic [1:0]  FCS_LAST   = 2'h3;

  typedef enum logic [2:0] {
    KIND_NONE  = 3'h0,
    KIND_SYNC  = 3'h1,
    KIND_DREQ  = 3'h2,
    KIND_ONEDM = 3'h3,
    KIND_DMM   = 3'h4,
    KIND_DMR   = 3'h5
  } potr_kind_type;

  typedef enum logic [1:0] {
    ACT_NONE       = 2'h0,
    ACT_WRITE      = 2'h1,
    ACT_WRITE_SAVE = 2'h2
  } potr_act_type;

  // Seconds in the upper word, nanoseconds below; delta is signed nanoseconds.
  function automatic logic [63:0] potr_ts_adjust(input logic [63:0] ts,
                                                 input logic [31:0] delta);
    logic signed [34:0] ns;
    logic [31:0]        sec;
    ns  = $signed({3'h0, ts[31:0]}) + $signed({{3{delta[31]}}, delta});
    sec = ts[63:32];
    if (ns < 0) begin
      ns  = ns + $signed({3'h0, NS_PER_SEC});
      sec = sec - 32'h1;
    end else if (ns >= $signed({3'h0, NS_PER_SEC})) begin
      ns  = ns - $signed({3'h0, NS_PER_SEC});
      sec = sec + 32'h1;
    end
    return {sec, ns[31:0]};
  endfunction : potr_ts_adjust

  function automatic logic potr_in_field(input logic [15:0] idx,
                                         input logic [15:0] off,
                                         input logic [3:0]  len);
    logic [15:0] rel;
    rel = idx - off;
    return (len != LEN_NONE) && (idx >= off) && (rel < {12'h000, len});
  endfunction : potr_in_field

  // Fields are big-endian: the first byte on the wire is the most significant.
  function automatic logic [7:0] potr_field_byte(input logic [63:0] val,
                                                 input logic [3:0]  len,
                                                 input logic [15:0] rel);
    logic [63:0] sh;
    logic [3:0]  pos;
    pos = len - 4'h1 - rel[3:0];
    sh  = val >> {pos[2:0], 3'h0};
    return sh[7:0];
  endfunction : potr_field_byte

  function automatic logic [31:0] potr_crc_byte(input logic [31:0] crc,
                                                input logic [7:0]  d);
    logic [31:0] c;
    c = crc ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : potr_crc_byte

endpackage : potr_pkg

/* pkg/potr_save_if.sv */
// Interface between the rewriter and its transmit stamp store.
`timescale 1ns/1ps
interface potr_save_if;
  logic        push;
  logic [79:0] push_id;
  logic [31:0] push_stamp;
  logic        pop;
  logic        head_valid;
  logic [79:0] head_id;
  logic [31:0] head_stamp;
  logic        drop;
  modport writer (output push, push_id, push_stamp, pop,
                  input  head_valid, head_id, head_stamp, drop);
  modport store  (input  push, push_id, push_stamp, pop,
                  output head_valid, head_id, head_stamp, drop);
endinterface : potr_save_if

/* src/potr_stamp_fifo.sv */
// Transmit stamp store: identifier and stamp pairs, head always at entry zero.
`timescale 1ns/1ps
module potr_stamp_fifo (
  input wire logic     clk_i,
  input wire logic     rst_i,
  potr_save_if.store   save
);

  logic [potr_pkg::ID_W-1:0]  id_q    [potr_pkg::FIFO_DEPTH];
  logic [potr_pkg::NS_W-1:0]  st_q    [potr_pkg::FIFO_DEPTH];
  logic [potr_pkg::CNT_W-1:0] cnt_q;
  logic [potr_pkg::CNT_W-1:0] cnt_d;
  logic [potr_pkg::CNT_W-1:0] wr_idx;
  logic                       valid_q;
  logic                       drop_q;
  logic                       do_pop;
  logic                       do_push;

  // A pop in the same cycle frees a slot, so a full store still accepts.
  assign do_pop  = save.pop && (cnt_q != 3'h0);
  assign do_push = save.push && ((cnt_q != 3'(potr_pkg::FIFO_DEPTH)) || do_pop);
  assign wr_idx  = do_pop ? cnt_q - 3'h1 : cnt_q;
  assign cnt_d   = cnt_q + {2'h0, do_push} - {2'h0, do_pop};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q   <= 3'h0;
      valid_q <= 1'h0;
      drop_q  <= 1'h0;
    end else begin
      cnt_q   <= cnt_d;
      valid_q <= cnt_d != 3'h0;
      drop_q  <= save.push && !do_push;
    end
  end

  for (genvar g = 0; g < potr_pkg::FIFO_DEPTH; g++) begin : g_entry
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        id_q[g] <= '0;
        st_q[g] <= '0;
      end else if (do_push && (wr_idx == 3'(g))) begin
        id_q[g] <= save.push_id;
        st_q[g] <= save.push_stamp;
      end else if (do_pop) begin
        if (g < potr_pkg::FIFO_DEPTH - 1) begin
          id_q[g] <= id_q[(g + 1) % potr_pkg::FIFO_DEPTH];
          st_q[g] <= st_q[(g + 1) % potr_pkg::FIFO_DEPTH];
        end
      end
    end
  end

  assign save.head_valid = valid_q;
  assign save.head_id    = id_q[0];
  assign save.head_stamp = st_q[0];
  assign save.drop       = drop_q;

endmodule : potr_stamp_fifo

/* src/potr_rewrite.sv */
// Per-direction frame time-stamp action logic with in-place rewrite and FCS regeneration.
`timescale 1ns/1ps
module potr_rewrite (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        EGRESS_I,
  input  wire logic        RX_VALID_I,
  input  wire logic [7:0]  RX_DATA_I,
  input  wire logic        RX_SOF_I,
  input  wire logic        RX_EOF_I,
  input  wire logic        CLASS_MATCH_I,
  input  wire logic [2:0]  CLASS_KIND_I,
  input  wire logic [15:0] RSVD_OFFSET_I,
  input  wire logic [15:0] STAMP_OFFSET_I,
  input  wire logic [15:0] CF_OFFSET_I,
  input  wire logic [63:0] CLASS_CF_I,
  input  wire logic [79:0] FRAME_ID_I,
  input  wire logic [63:0] CAPTURED_TIME_VALUE_I,
  input  wire logic [31:0] LOCAL_CORR_I,
  input  wire logic [31:0] ASYMMETRY_I,
  input  wire logic        FIFO_POP_I,
  output logic             TX_VALID_O,
  output logic [7:0]       TX_DATA_O,
  output logic             TX_SOF_O,
  output logic             TX_EOF_O,
  output logic             FIFO_VALID_O,
  output logic [79:0]      FIFO_ID_O,
  output logic [31:0]      FIFO_STAMP_O,
  output logic             FIFO_DROP_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************

  potr_save_if save_bus ();

  potr_pkg::potr_kind_type kind;
  potr_pkg::potr_act_type  act_d;
  potr_pkg::potr_act_type  act_q;

  logic        rx_start;
  logic        matched;
  logic [63:0] ts_sub;
  logic [63:0] ts_add;
  logic [63:0] ts_dreq;
  logic [63:0] cf_new;

  logic [15:0] a_off_d;
  logic [3:0]  a_len_d;
  logic [63:0] a_val_d;
  logic [15:0] b_off_d;
  logic [3:0]  b_len_d;
  logic [63:0] b_val_d;
  logic        save_d;
  logic [31:0] save_stamp_d;

  logic [15:0] a_off_q;
  logic [3:0]  a_len_q;
  logic [63:0] a_val_q;
  logic [15:0] b_off_q;
  logic [3:0]  b_len_q;
  logic [63:0] b_val_q;
  logic        push_q;
  logic [79:0] push_id_q;
  logic [31:0] push_stamp_q;

  logic [15:0] idx_q;
  logic [7:0]  ent_data;

  logic        st_valid_q [potr_pkg::PIPE_DEPTH];
  logic [7:0]  st_data_q  [potr_pkg::PIPE_DEPTH];
  logic        st_sof_q   [potr_pkg::PIPE_DEPTH];
  logic        st_eof_q   [potr_pkg::PIPE_DEPTH];
  logic        st_fcs_q   [potr_pkg::PIPE_DEPTH];
  logic [1:0]  st_fidx_q  [potr_pkg::PIPE_DEPTH];
  logic        st_rw_q    [potr_pkg::PIPE_DEPTH];

  logic [31:0] crc_q;
  logic        out_valid;
  logic [7:0]  out_data;
  logic        out_sof;
  logic        out_eof;
  logic        out_fcs;
  logic [1:0]  out_fidx;
  logic        out_rw;
  logic [31:0] fcs_word;

  // ****************************************************************
  // Frame classification and action selection
  // ****************************************************************

  assign rx_start = RX_VALID_I && RX_SOF_I;
  assign kind     = potr_pkg::potr_kind_type'(CLASS_KIND_I);
  assign matched  = CLASS_MATCH_I && (kind != potr_pkg::KIND_NONE);

  // The stamp is taken at the start of frame, so every correction is
  // settled before the first byte of any field reaches the rewriter.
  assign ts_sub  = potr_pkg::potr_ts_adjust(CAPTURED_TIME_VALUE_I,
                                            32'h00000000 - LOCAL_CORR_I);
  assign ts_add  = potr_pkg::potr_ts_adjust(CAPTURED_TIME_VALUE_I, LOCAL_CORR_I);
  assign ts_dreq = potr_pkg::potr_ts_adjust(CAPTURED_TIME_VALUE_I,
                                            LOCAL_CORR_I - ASYMMETRY_I);
  assign cf_new  = CLASS_CF_I + {{32{ASYMMETRY_I[31]}}, ASYMMETRY_I};

  always_comb begin
    act_d        = potr_pkg::ACT_NONE;
    a_off_d      = 16'h0000;
    a_len_d      = potr_pkg::LEN_NONE;
    a_val_d      = 64'h0000000000000000;
    b_off_d      = 16'h0000;
    b_len_d      = potr_pkg::LEN_NONE;
    b_val_d      = 64'h0000000000000000;
    save_d       = 1'h0;
    save_stamp_d = 32'h00000000;
    if (matched) begin
      unique case (kind)
        potr_pkg::KIND_SYNC,
        potr_pkg::KIND_DREQ: begin
          a_off_d = RSVD_OFFSET_I;
          a_len_d = potr_pkg::LEN_RSVD;
          if (EGRESS_I) begin
            // Stamp value is zero; only the transmit stamp goes to the store.
            act_d   = potr_pkg::ACT_WRITE_SAVE;
            a_val_d = 64'h0000000000000000;
            save_d  = 1'h1;
            if (kind == potr_pkg::KIND_SYNC) begin
              save_stamp_d = ts_add[31:0];
            end else begin
              save_stamp_d = ts_dreq[31:0];
            end
          end else begin
            act_d   = potr_pkg::ACT_WRITE;
            a_val_d = {32'h00000000, ts_sub[31:0]};
            if (kind == potr_pkg::KIND_SYNC) begin
              b_off_d = CF_OFFSET_I;
              b_len_d = potr_pkg::LEN_STAMP;
              b_val_d = cf_new;
            end
          end
        end
        potr_pkg::KIND_ONEDM,
        potr_pkg::KIND_DMM,
        potr_pkg::KIND_DMR: begin
          // Software leaves the transmit field empty; it is overwritten here.
          act_d   = potr_pkg::ACT_WRITE;
          a_off_d = STAMP_OFFSET_I;
          a_len_d = potr_pkg::LEN_STAMP;
          a_val_d = EGRESS_I ? ts_add : ts_sub;
        end
        default: begin
          act_d = potr_pkg::ACT_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      act_q   <= potr_pkg::ACT_NONE;
      a_off_q <= 16'h0000;
      a_len_q <= potr_pkg::LEN_NONE;
      a_val_q <= 64'h0000000000000000;
      b_off_q <= 16'h0000;
      b_len_q <= potr_pkg::LEN_NONE;
      b_val_q <= 64'h0000000000000000;
    end else if (rx_start) begin
      act_q   <= act_d;
      a_off_q <= a_off_d;
      a_len_q <= a_len_d;
      a_val_q <= a_val_d;
      b_off_q <= b_off_d;
      b_len_q <= b_len_d;
      b_val_q <= b_val_d;
    end
  end

  // ****************************************************************
  // Transmit stamp store
  // ****************************************************************

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      push_q       <= 1'h0;
      push_id_q    <= 80'h00000000000000000000;
      push_stamp_q <= 32'h00000000;
    end else begin
      push_q <= rx_start && save_d;
      if (rx_start) begin
        push_id_q    <= FRAME_ID_I;
        push_stamp_q <= save_stamp_d;
      end
    end
  end

  assign save_bus.push       = push_q;
  assign save_bus.push_id    = push_id_q;
  assign save_bus.push_stamp = push_stamp_q;
  assign save_bus.pop        = FIFO_POP_I;

  potr_stamp_fifo u_fifo (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .save  (save_bus.store)
  );

  assign FIFO_VALID_O = save_bus.head_valid;
  assign FIFO_ID_O    = save_bus.head_id;
  assign FIFO_STAMP_O = save_bus.head_stamp;
  assign FIFO_DROP_O  = save_bus.drop;

  // ****************************************************************
  // In-place field overwrite
  // ****************************************************************

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      idx_q <= 16'h0000;
    end else if (RX_VALID_I) begin
      idx_q <= rx_start ? potr_pkg::IDX_FIRST : idx_q + 16'h0001;
    end
  end

  // Byte zero is never a field, which leaves the start cycle free to load
  // the plan registers.
  always_comb begin
    ent_data = RX_DATA_I;
    if (!rx_start && potr_pkg::potr_in_field(idx_q, a_off_q, a_len_q)) begin
      ent_data = potr_pkg::potr_field_byte(a_val_q, a_len_q, idx_q - a_off_q);
    end else if (!rx_start && potr_pkg::potr_in_field(idx_q, b_off_q, b_len_q)) begin
      ent_data = potr_pkg::potr_field_byte(b_val_q, b_len_q, idx_q - b_off_q);
    end
  end

  // ****************************************************************
  // Delay line that exposes the trailer
  // ****************************************************************

  // Four bytes of delay let the last four bytes be recognised as the
  // trailer when the end marker arrives, with no change in length.
  for (genvar k = 0; k < potr_pkg::PIPE_DEPTH; k++) begin : g_stage
    logic       src_valid;
    logic [7:0] src_data;
    logic       src_sof;
    logic       src_eof;
    logic       src_fcs;
    logic [1:0] src_fidx;
    logic       src_rw;
    if (k == 0) begin : g_head
      assign src_valid = RX_VALID_I;
      assign src_data  = ent_data;
      assign src_sof   = rx_start;
      assign src_eof   = RX_VALID_I && RX_EOF_I;
      assign src_fcs   = 1'h0;
      assign src_fidx  = 2'h0;
      assign src_rw    = act_q != potr_pkg::ACT_NONE;
    end else begin : g_tail
      assign src_valid = st_valid_q[k-1];
      assign src_data  = st_data_q[k-1];
      assign src_sof   = st_sof_q[k-1];
      assign src_eof   = st_eof_q[k-1];
      assign src_fcs   = st_fcs_q[k-1];
      assign src_fidx  = st_fidx_q[k-1];
      assign src_rw    = st_rw_q[k-1];
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
        st_valid_q[k] <= 1'h0;
        st_data_q[k]  <= 8'h00;
        st_sof_q[k]   <= 1'h0;
        st_eof_q[k]   <= 1'h0;
        st_fcs_q[k]   <= 1'h0;
        st_fidx_q[k]  <= 2'h0;
        st_rw_q[k]    <= 1'h0;
      end else begin
        st_valid_q[k] <= src_valid;
        st_data_q[k]  <= src_data;
        st_sof_q[k]   <= src_sof;
        st_eof_q[k]   <= src_eof;
        st_rw_q[k]    <= src_rw;
        if (RX_VALID_I && RX_EOF_I && src_valid) begin
          st_fcs_q[k]  <= 1'h1;
          st_fidx_q[k] <= potr_pkg::FCS_LAST - 2'(k);
        end else begin
          st_fcs_q[k]  <= src_fcs;
          st_fidx_q[k] <= src_fidx;
        end
      end
    end
  end

  // ****************************************************************
  // Trailer regeneration and output
  // ****************************************************************

  assign out_valid = st_valid_q[potr_pkg::PIPE_DEPTH-1];
  assign out_data  = st_data_q[potr_pkg::PIPE_DEPTH-1];
  assign out_sof   = st_sof_q[potr_pkg::PIPE_DEPTH-1];
  assign out_eof   = st_eof_q[potr_pkg::PIPE_DEPTH-1];
  assign out_fcs   = st_fcs_q[potr_pkg::PIPE_DEPTH-1];
  assign out_fidx  = st_fidx_q[potr_pkg::PIPE_DEPTH-1];
  assign out_rw    = st_rw_q[potr_pkg::PIPE_DEPTH-1];
  assign fcs_word  = ~crc_q;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      crc_q <= potr_pkg::CRC_INIT;
    end else if (out_valid && !out_fcs) begin
      crc_q <= potr_pkg::potr_crc_byte(out_sof ? potr_pkg::CRC_INIT : crc_q,
                                       out_data);
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      TX_VALID_O <= 1'h0;
      TX_DATA_O  <= 8'h00;
      TX_SOF_O   <= 1'h0;
      TX_EOF_O   <= 1'h0;
    end else begin
      TX_VALID_O <= out_valid;
      TX_SOF_O   <= out_sof;
      TX_EOF_O   <= out_eof;
      // Untouched frames keep their own trailer, bit for bit.
      if (out_valid && out_fcs && out_rw) begin
        TX_DATA_O <= fcs_word[{out_fidx, 3'h0} +: 8];
      end else begin
        TX_DATA_O <= out_data;
      end
    end
  end

endmodule : potr_rewrite

/* bench/potr_rewrite_assertions.sv */
// Port-level checker for the frame time-stamp rewrite block.
`timescale 1ns/1ps
module potr_rewrite_assertions (
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        EGRESS_I,
  input wire logic        RX_VALID_I,
  input wire logic [7:0]  RX_DATA_I,
  input wire logic        RX_SOF_I,
  input wire logic        RX_EOF_I,
  input wire logic        CLASS_MATCH_I,
  input wire logic [2:0]  CLASS_KIND_I,
  input wire logic [79:0] FRAME_ID_I,
  input wire logic        FIFO_POP_I,
  input wire logic        TX_VALID_O,
  input wire logic [7:0]  TX_DATA_O,
  input wire logic        TX_SOF_O,
  input wire logic        TX_EOF_O,
  input wire logic        FIFO_VALID_O,
  input wire logic [79:0] FIFO_ID_O,
  input wire logic        FIFO_DROP_O
);
  logic pass_q;
  logic pass_d;
  logic pass_now;
  logic save_d;
  assign pass_d   = !CLASS_MATCH_I || CLASS_KIND_I == 3'h0 || CLASS_KIND_I > 3'h5;
  assign pass_now = RX_SOF_I ? pass_d : pass_q;
  assign save_d   = RX_VALID_I && RX_SOF_I && EGRESS_I && CLASS_MATCH_I &&
                    (CLASS_KIND_I == 3'h1 || CLASS_KIND_I == 3'h2);
  // The SOF cycle carries the plan, so later bytes use the remembered verdict.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pass_q <= 1'b0;
    end else if (RX_VALID_I && RX_SOF_I) begin
      pass_q <= pass_d;
    end
  end
  default clocking main_cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  sof_delay_a: assert property (
    RX_VALID_I && RX_SOF_I |-> ##5 TX_SOF_O && TX_VALID_O) else $error("late start of frame");
  eof_delay_a: assert property (
    RX_VALID_I && RX_EOF_I |-> ##5 TX_EOF_O) else $error("late end of frame");
  valid_delay_a: assert property (
    RX_VALID_I |-> ##5 TX_VALID_O) else $error("byte lost");
  gap_kept_a: assert property (
    !RX_VALID_I |-> ##5 !TX_VALID_O) else $error("idle gap changed");
  pass_data_a: assert property (
    RX_VALID_I && pass_now |-> ##5 TX_DATA_O == $past(RX_DATA_I, 5))
    else $error("unmatched byte altered");
  save_push_a: assert property (
    save_d && !FIFO_VALID_O |-> ##2 FIFO_VALID_O && FIFO_ID_O == $past(FRAME_ID_I, 2))
    else $error("save not stored");
  no_save_a: assert property (
    RX_VALID_I && RX_SOF_I && !save_d && !FIFO_VALID_O |-> ##2 !FIFO_VALID_O)
    else $error("unexpected save");
  head_hold_a: assert property (
    FIFO_VALID_O && !FIFO_POP_I && !$past(FIFO_POP_I) |=> FIFO_VALID_O && $stable(FIFO_ID_O))
    else $error("head changed without pop");
  drop_pulse_a: assert property (
    FIFO_DROP_O |-> FIFO_VALID_O ##1 !FIFO_DROP_O) else $error("bad drop pulse");
endmodule : potr_rewrite_assertions

bind potr_rewrite potr_rewrite_assertions potr_rewrite_assertions_inst (.CLK_I, .RST_I,
  .EGRESS_I, .RX_VALID_I, .RX_DATA_I, .RX_SOF_I, .RX_EOF_I, .CLASS_MATCH_I, .CLASS_KIND_I,
  .FRAME_ID_I, .FIFO_POP_I, .TX_VALID_O, .TX_DATA_O, .TX_SOF_O, .TX_EOF_O, .FIFO_VALID_O,
  .FIFO_ID_O, .FIFO_DROP_O);

/* bench/potr_mac_model.sv */
// Byte source standing in for the MAC or PCS that feeds the rewrite path.
`timescale 1ns/1ps
module potr_mac_model (
  input  wire logic       clk_i,
  output logic            valid_o = 1'b0,
  output logic [7:0]      data_o = 8'h00,
  output logic            sof_o = 1'b0,
  output logic            eof_o = 1'b0
);
  logic [7:0] q[$];
  int         idle = 8;
  // Idle data keeps toggling so a stale byte can never pass for a frame byte.
  always @(negedge clk_i) begin
    // A frame runs on only up to its end marker; the next frame waits out the idle gap.
    if (q.size() > 0 && ((valid_o && !eof_o) || idle >= 4)) begin
      sof_o   <= !valid_o;
      valid_o <= 1'b1;
      data_o  <= q.pop_front();
      eof_o   <= q.size() == 0;
      idle    <= 0;
    end else begin
      sof_o   <= 1'b0;
      valid_o <= 1'b0;
      eof_o   <= 1'b0;
      data_o  <= ~data_o;
      idle    <= idle + 1;
    end
  end
  task automatic send(input logic [7:0] f[$]);
    q = f;
    // Returning on the opposite edge keeps the caller out of the time step of the last pop.
    while (q.size() > 0) @(posedge clk_i);
  endtask : send
endmodule : potr_mac_model

/* bench/ptp_oam_timestamp_rewrite_tb_top.sv */
// Self-checking bench for the frame time-stamp rewrite block.
`timescale 1ns/1ps
module ptp_oam_timestamp_rewrite_tb_top;
  logic         clk = 1'b0, rst = 1'b1, egress = 1'b0, match = 1'b0, pop = 1'b0;
  logic [2:0]   kind = 3'h0;
  logic [15:0]  rsvd_off = 16'h0010, stamp_off = 16'h0018, cf_off = 16'h0008;
  logic [63:0]  cf = 64'h0, ts = 64'h0;
  logic [79:0]  fid = 80'h0;
  logic [31:0]  lc = 32'h0, asym = 32'h0, st = 32'h14BC;
  logic         rx_valid, rx_sof, rx_eof, tx_valid, tx_sof, tx_eof, f_valid, f_drop;
  logic [7:0]   rx_data, tx_data;
  logic [79:0]  f_id;
  logic [31:0]  f_stamp;
  int           fail_count = 0, total_checks = 0, drops_exp = 0, drops_seen = 0;
  logic [8:0]   exp_b[$];
  logic [111:0] fq[$];

  always #50 clk = ~clk;

  potr_rewrite potr_rewrite_inst (.CLK_I(clk), .RST_I(rst), .EGRESS_I(egress),
    .RX_VALID_I(rx_valid), .RX_DATA_I(rx_data), .RX_SOF_I(rx_sof), .RX_EOF_I(rx_eof),
    .CLASS_MATCH_I(match), .CLASS_KIND_I(kind), .RSVD_OFFSET_I(rsvd_off),
    .STAMP_OFFSET_I(stamp_off), .CF_OFFSET_I(cf_off), .CLASS_CF_I(cf), .FRAME_ID_I(fid),
    .CAPTURED_TIME_VALUE_I(ts), .LOCAL_CORR_I(lc), .ASYMMETRY_I(asym), .FIFO_POP_I(pop),
    .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data), .TX_SOF_O(tx_sof), .TX_EOF_O(tx_eof),
    .FIFO_VALID_O(f_valid), .FIFO_ID_O(f_id), .FIFO_STAMP_O(f_stamp), .FIFO_DROP_O(f_drop));
  potr_mac_model potr_mac_model_inst (.clk_i(clk), .valid_o(rx_valid), .data_o(rx_data),
    .sof_o(rx_sof), .eof_o(rx_eof));

  // ************************************************************
  // Reference model helpers
  // ************************************************************
  function automatic logic [31:0] rnd();
    st = {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
    return st;
  endfunction : rnd

  // Nanoseconds wrap at one second with carry or borrow into the seconds word.
  function automatic logic [63:0] adj(input logic [63:0] t, input int d);
    longint n;
    n = longint'(t[31:0]) + d;
    if (n < 0) return {t[63:32] - 32'h1, 32'(n + 64'sh3B9ACA00)};
    if (n >= 64'sh3B9ACA00) return {t[63:32] + 32'h1, 32'(n - 64'sh3B9ACA00)};
    return {t[63:32], 32'(n)};
  endfunction : adj

  function automatic logic [31:0] crc_of(input logic [7:0] f[$], input int n);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < n; i++) begin
      c ^= {24'h0, f[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction : crc_of

  task automatic check(input logic [111:0] seen, input logic [111:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  always @(negedge clk) begin
    if (tx_valid === 1'b1) begin
      if (exp_b.size() == 0) check(tx_data, 9'h1FF);
      else check({tx_eof, tx_data}, exp_b.pop_front());
    end
    if (f_drop === 1'b1) drops_seen++;
  end

  task automatic send_frame(input bit eg, input logic [2:0] k, input bit m);
    logic [7:0]  f[$];
    logic [7:0]  e[$];
    logic [63:0] v;
    logic [31:0] c;
    int          n;
    n = 40 + int'(rnd() % 24);
    for (int i = 0; i < n; i++) f.push_back(8'(rnd()));
    if (eg && (k == 3'h3 || k == 3'h4)) for (int j = 0; j < 8; j++) f[24 + j] = 8'h0;
    @(negedge clk);
    egress = eg;
    kind = k;
    match = m;
    cf = {rnd(), rnd()};
    fid = {16'(rnd()), rnd(), rnd()};
    ts = {rnd(), k == 3'h3 ? 32'h5 : k == 3'h4 ? 32'h3B9AC9FB : rnd() % 32'h3B9ACA00};
    lc = $signed(rnd()) >>> 12;
    asym = $signed(rnd()) >>> 12;
    e = f;
    if (m && k != 3'h0 && k <= 3'h5) begin
      if (k >= 3'h3) begin
        v = adj(ts, eg ? int'(lc) : -int'(lc));
        for (int j = 0; j < 8; j++) e[24 + j] = v[63 - 8 * j -: 8];
      end else begin
        v = eg ? 64'h0 : adj(ts, -int'(lc));
        for (int j = 0; j < 4; j++) e[16 + j] = v[31 - 8 * j -: 8];
        v = cf + {{32{asym[31]}}, asym};
        if (!eg && k == 3'h1) for (int j = 0; j < 8; j++) e[8 + j] = v[63 - 8 * j -: 8];
        v = adj(ts, int'(lc) - (k == 3'h2 ? int'(asym) : 0));
        if (eg && fq.size() < 4) fq.push_back({fid, v[31:0]});
        else if (eg) drops_exp++;
      end
      c = crc_of(e, n - 4);
      for (int j = 0; j < 4; j++) e[n - 4 + j] = c[8 * j +: 8];
    end
    for (int i = 0; i < n; i++) exp_b.push_back({i == n - 1, e[i]});
    potr_mac_model_inst.send(f);
  endtask : send_frame

  task automatic drain();
    repeat (12) @(negedge clk);
    for (int i = 0; i < 6 && f_valid === 1'b1; i++) begin
      check({f_id, f_stamp}, fq.size() > 0 ? fq.pop_front() : 112'h0);
      pop = 1'b1;
      @(negedge clk);
      pop = 1'b0;
      repeat (2) @(negedge clk);
    end
    check(fq.size(), 0);
    pop = 1'b1;
    repeat (2) @(negedge clk);
    pop = 1'b0;
    check(f_valid, 1'b0);
  endtask : drain

  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    for (int d = 0; d < 2; d++) begin
      for (int k = 0; k < 8; k++) begin
        send_frame(d[0], k[2:0], 1'b1);
        send_frame(d[0], k[2:0], 1'b0);
        drain();
      end
    end
    // Five back-to-back saves into a four-deep store: the last one is lost.
    for (int i = 0; i < 5; i++) send_frame(1'b1, 3'(1 + i % 2), 1'b1);
    drain();
    check(drops_seen, drops_exp);
    check(exp_b.size(), 0);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule : ptp_oam_timestamp_rewrite_tb_top
